// file: include/hspcs_consts.vh
// Purpose: Constants for the handshake port command and status block.
// Assumes: Register indices; the byte address is four times the index.
// Notes: Command codes sit in bits 7..5 of a command/status write.
`ifndef HSPCS_CONSTS_VH
`define HSPCS_CONSTS_VH
// ****************************************************************
// Register indices
// ****************************************************************
`define HSPCS_IDX_CMD_A 6'h08
`define HSPCS_IDX_CMD_B 6'h09
`define HSPCS_IDX_HS_A 6'h21
`define HSPCS_IDX_HS_B 6'h29
`define HSPCS_IDX_MODE_A 6'h20
`define HSPCS_IDX_MODE_B 6'h28
`define HSPCS_IDX_DATA_A 6'h0D
`define HSPCS_IDX_DATA_B 6'h0E
`define HSPCS_IDX_PC_DIR 6'h06
// ****************************************************************
// Reset values and fields
// ****************************************************************
`define HSPCS_HS_RESET 8'h00
`define HSPCS_MODE_RESET 8'h00
`define HSPCS_PC_DIR_RESET 4'h0
`define HSPCS_PC_UPPER 4'hF
`define HSPCS_KIND_BIT 2'h0
`define HSPCS_KIND_IN 2'h1
`define HSPCS_KIND_OUT 2'h2
`define HSPCS_KIND_BIDIR 2'h3
`define HSPCS_HSK_INTERLOCK 2'h0
`define HSPCS_HSK_STROBED 2'h1
`define HSPCS_HSK_PULSED 2'h2
`define HSPCS_HSK_THREEWIRE 2'h3
`define HSPCS_PMS_OFF 2'h0
`define HSPCS_PMS_VECTOR 2'h3
`define HSPCS_RW_OFF 3'h0
`define HSPCS_RW_OUT_WAIT 3'h1
`define HSPCS_RW_IN_WAIT 3'h3
`define HSPCS_RW_SPECIAL 3'h4
`define HSPCS_RW_OUT_REQ 3'h5
`define HSPCS_RW_IN_REQ 3'h7
// ****************************************************************
// Command codes
// ****************************************************************
`define HSPCS_CMD_NULL 3'h0
`define HSPCS_CMD_CLR_BOTH 3'h1
`define HSPCS_CMD_SET_US 3'h2
`define HSPCS_CMD_CLR_US 3'h3
`define HSPCS_CMD_SET_REQ 3'h4
`define HSPCS_CMD_CLR_REQ 3'h5
`define HSPCS_CMD_SET_IE 3'h6
`define HSPCS_CMD_CLR_IE 3'h7
// ****************************************************************
// Timing and bus answers
// ****************************************************************
`define HSPCS_SKEW_STEP 5'h02
`define HSPCS_RESP_OKAY 2'h0
`define HSPCS_RESP_SLVERR 2'h2
`endif

// file: src/hspcs_sync2.v
// Purpose: Two flip-flop synchroniser for pin inputs.
// Assumes: Inputs are asynchronous to clock.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/1ps
module hspcs_sync2 #(
   parameter WIDTH = 1
) (
   input wire clock,
   input wire reset,
   input wire [WIDTH-1:0] d,
   output reg [WIDTH-1:0] q
);
   reg [WIDTH-1:0] stage1;
   always @(posedge clock) begin
      if (reset) begin
         stage1 <= {WIDTH{1'b0}};
         q <= {WIDTH{1'b0}};
      end else begin
         stage1 <= d;
         q <= stage1;
      end
   end
endmodule

// file: src/hspcs_deskew.v
// Purpose: Deskew timer between a new output byte and data-valid.
// Assumes: start is a one-cycle pulse.
// Notes: Delay is (count + 1) * 2 + 1 cycles when enabled, else one cycle.
`timescale 1ns/1ps
`include "hspcs_consts.vh"
module hspcs_deskew (
   input wire clock,
   input wire reset,
   input wire start,
   input wire enable,
   input wire [2:0] count,
   output reg done
);
   reg [4:0] remain;
   reg busy;
   wire [4:0] load = (({2'b00, count}) + 5'h01) * `HSPCS_SKEW_STEP;
   always @(posedge clock) begin
      if (reset) begin
         remain <= 5'h00;
         busy <= 1'b0;
         done <= 1'b0;
      end else begin
         done <= 1'b0;
         if (start) begin
            busy <= enable;
            remain <= load - 5'h01;
            done <= ~enable;
         end else if (busy) begin
            if (remain == 5'h00) begin
               busy <= 1'b0;
               done <= 1'b1;
            end else begin
               remain <= remain - 5'h01;
            end
         end
      end
   end
endmodule

// file: src/hspcs_top.v
// Purpose: Two 8-bit handshake ports with command/status flags over AXI4-Lite.
// Assumes: matchHit comes from pattern logic on the same clock; other pins are async.
// Notes: Port A has higher interrupt priority than port B.
// How it works
// [R1] handshake_kind picks interlocked, strobed, pulsed or three-wire handshake.
// [R2] Software avoids pulsed or three-wire on bidirectional ports and shared conflicts.
// [R3] req_wait_use picks disabled, output/input wait, special, output/input request.
// [R4] Software makes the other port a bit port when request/wait is used.
// [R5] skew_delay_count sets minimum cycles between new output byte and data-valid low.
// [R6] With skew_timer_on clear there is no deskew delay.
// [R7] Handshake setup is ignored in bit ports; resets to zero; fully read/write.
// [R8] Reset sets output_empty_flag, clears others; all readable, four writable.
// [R9] under_service set by acknowledge or command, cleared by command, blocks chain.
// [R10] int_enable low masks service_request but flags and chain still work.
// [R11] service_request set by match, handshake, error or command; drives irq.
// [R12] fault_flag set on repeated match while request pending; cleared with request.
// [R13] output_empty_flag set on byte out, cleared by data write; forced in bit port.
// [R14] input_full_flag set by input handshake, cleared by data read; zero otherwise.
// [R15] match_flag unlatched in bit port, updated per byte move otherwise.
// [R16] halt_on_fault makes repeated match an error that halts the port.
// [R17] Status flags ignore writes; interrupt bits change only through command codes.
// [R18] Auxiliary port bit-path register upper four bits read as ones.
// [R19] port_kind selects bit, input, output or bidirectional port.
// [R20] Deskew only for output ports with skew_timer_on set.
// [R21] Command code in bits 7..5 sets or clears interrupt bits separately.
//
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "hspcs_consts.vh"
module hspcs_top (
   input wire clock,
   input wire reset,
   input wire [7:0] awaddr,
   input wire awvalid,
   output reg awready,
   input wire [31:0] wdata,
   input wire [3:0] wstrb,
   input wire wvalid,
   output reg wready,
   output reg [1:0] bresp,
   output reg bvalid,
   input wire bready,
   input wire [7:0] araddr,
   input wire arvalid,
   output reg arready,
   output reg [31:0] rdata,
   output reg [1:0] rresp,
   output reg rvalid,
   input wire rready,
   input wire [15:0] dataIn,
   input wire [1:0] strobeInN,
   input wire [1:0] ackIn,
   input wire [1:0] matchHit,
   input wire intAck,
   input wire chainIn,
   output reg [15:0] dataOut,
   output reg [1:0] newByteValidN,
   output reg [1:0] reqWait,
   output reg irqOutN,
   output reg chainOut
);
   // ****************************************************************
   // Pin synchronisers and edges
   // ****************************************************************
   wire [21:0] syncQ;
   reg [5:0] syncLast;
   hspcs_sync2 #(.WIDTH(22)) pinSync (
      .clock(clock),
      .reset(reset),
      .d({chainIn, intAck, ackIn, strobeInN, dataIn}),
      .q(syncQ)
   );
   wire [15:0] pinData = syncQ[15:0];
   wire [1:0] strobeFall = syncLast[1:0] & ~syncQ[17:16];
   wire [1:0] ackLevel = syncQ[19:18];
   wire [1:0] ackRise = ~syncLast[3:2] & syncQ[19:18];
   wire ackStart = ~syncLast[4] & syncQ[20];
   wire chainOk = syncQ[21];
   always @(posedge clock) begin
      if (reset) begin
         syncLast <= 6'h00;
      end else begin
         syncLast <= syncQ[21:16];
      end
   end
   // ****************************************************************
   // AXI4-Lite slave
   // ****************************************************************
   reg awHeld;
   reg wHeld;
   reg [5:0] awIdx;
   reg [7:0] wByte;
   reg wLane0;
   reg wrEn;
   reg [5:0] wrIdx;
   reg [7:0] wrByte;
   reg rdEn;
   reg [5:0] rdIdx;
   reg [3:0] pcDir;
   reg [7:0] rdMux;
   reg rdHit;
   reg wrHit;
   wire [15:0] statusV;
   wire [15:0] hsV;
   wire [15:0] modeV;
   wire [15:0] inV;
   always @* begin
      case (awIdx)
         `HSPCS_IDX_CMD_A, `HSPCS_IDX_CMD_B, `HSPCS_IDX_HS_A, `HSPCS_IDX_HS_B,
         `HSPCS_IDX_MODE_A, `HSPCS_IDX_MODE_B, `HSPCS_IDX_DATA_A, `HSPCS_IDX_DATA_B,
         `HSPCS_IDX_PC_DIR: wrHit = 1'b1;
         default: wrHit = 1'b0;
      endcase
   end
   always @* begin
      rdHit = 1'b1;
      case (rdIdx)
         `HSPCS_IDX_CMD_A: rdMux = statusV[7:0];
         `HSPCS_IDX_CMD_B: rdMux = statusV[15:8];
         `HSPCS_IDX_HS_A: rdMux = hsV[7:0];
         `HSPCS_IDX_HS_B: rdMux = hsV[15:8];
         `HSPCS_IDX_MODE_A: rdMux = modeV[7:0];
         `HSPCS_IDX_MODE_B: rdMux = modeV[15:8];
         `HSPCS_IDX_DATA_A: rdMux = inV[7:0];
         `HSPCS_IDX_DATA_B: rdMux = inV[15:8];
         `HSPCS_IDX_PC_DIR: rdMux = {`HSPCS_PC_UPPER, pcDir}; // [R18]
         default: begin
            rdMux = 8'h00;
            rdHit = 1'b0;
         end
      endcase
   end
   always @(posedge clock) begin
      if (reset) begin
         awready <= 1'b1;
         wready <= 1'b1;
         awHeld <= 1'b0;
         wHeld <= 1'b0;
         awIdx <= 6'h00;
         wByte <= 8'h00;
         wLane0 <= 1'b0;
         bvalid <= 1'b0;
         bresp <= `HSPCS_RESP_OKAY;
         wrEn <= 1'b0;
         wrIdx <= 6'h00;
         wrByte <= 8'h00;
         pcDir <= `HSPCS_PC_DIR_RESET;
      end else begin
         wrEn <= 1'b0;
         if (awvalid && awready) begin
            awready <= 1'b0;
            awHeld <= 1'b1;
            awIdx <= awaddr[7:2];
         end
         if (wvalid && wready) begin
            wready <= 1'b0;
            wHeld <= 1'b1;
            wByte <= wdata[7:0];
            wLane0 <= wstrb[0];
         end
         if (awHeld && wHeld && !bvalid) begin
            bvalid <= 1'b1;
            bresp <= wrHit ? `HSPCS_RESP_OKAY : `HSPCS_RESP_SLVERR;
            wrEn <= wrHit & wLane0;
            wrIdx <= awIdx;
            wrByte <= wByte;
            if (wrHit && wLane0 && awIdx == `HSPCS_IDX_PC_DIR) begin
               pcDir <= wByte[3:0]; // [R18]
            end
         end
         if (bvalid && bready) begin
            bvalid <= 1'b0;
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            awready <= 1'b1;
            wready <= 1'b1;
         end
      end
   end
   always @(posedge clock) begin
      if (reset) begin
         arready <= 1'b1;
         rvalid <= 1'b0;
         rdata <= 32'h00000000;
         rresp <= `HSPCS_RESP_OKAY;
         rdEn <= 1'b0;
         rdIdx <= 6'h00;
      end else begin
         rdEn <= 1'b0;
         if (arvalid && arready) begin
            arready <= 1'b0;
            rdEn <= 1'b1;
            rdIdx <= araddr[7:2];
         end
         if (rdEn) begin
            rvalid <= 1'b1;
            rdata <= {24'h000000, rdMux};
            rresp <= rdHit ? `HSPCS_RESP_OKAY : `HSPCS_RESP_SLVERR;
         end
         if (rvalid && rready) begin
            rvalid <= 1'b0;
            arready <= 1'b1;
         end
      end
   end
   // ****************************************************************
   // Interrupt daisy chain, port A first
   // ****************************************************************
   wire [1:0] iusV;
   wire [1:0] reqV;
   wire [1:0] ackSel;
   assign ackSel[0] = ackStart & chainOk & reqV[0]; // [R9]
   assign ackSel[1] = ackStart & chainOk & ~iusV[0] & ~reqV[0] & reqV[1]; // [R9]
   always @(posedge clock) begin
      if (reset) begin
         irqOutN <= 1'b1;
         chainOut <= 1'b0;
      end else begin
         irqOutN <= ~(chainOk & (reqV[0] | (~iusV[0] & reqV[1]))); // [R11]
         chainOut <= chainOk & ~iusV[0] & ~iusV[1]; // [R9]
      end
   end
   // ****************************************************************
   // Per-port command, status and handshake logic
   // ****************************************************************
   localparam TX_IDLE = 2'h0;
   localparam TX_SKEW = 2'h1;
   localparam TX_VALID = 2'h2;
   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : port
         localparam [5:0] CMD_IDX = (g == 0) ? `HSPCS_IDX_CMD_A : `HSPCS_IDX_CMD_B;
         localparam [5:0] HS_IDX = (g == 0) ? `HSPCS_IDX_HS_A : `HSPCS_IDX_HS_B;
         localparam [5:0] MODE_IDX = (g == 0) ? `HSPCS_IDX_MODE_A : `HSPCS_IDX_MODE_B;
         localparam [5:0] DATA_IDX = (g == 0) ? `HSPCS_IDX_DATA_A : `HSPCS_IDX_DATA_B;
         reg [7:0] hsSetup;
         reg [7:0] modeReg;
         reg underService;
         reg intEnable;
         reg serviceRequest;
         reg faultFlag;
         reg haltOnFault;
         reg outputEmpty;
         reg inputFull;
         reg matchFlag;
         reg phase;
         reg matchLast;
         reg [7:0] inData;
         reg [1:0] txState;
         reg skewStart;
         wire skewDone;
         wire [1:0] portKind = modeReg[7:6];
         wire [1:0] matchMode = modeReg[2:1];
         wire skewTimerOn = modeReg[0];
         wire bitPort = (portKind == `HSPCS_KIND_BIT); // [R19]
         wire hasIn = portKind[0]; // [R19]
         wire hasOut = portKind[1]; // [R19]
         wire [1:0] handshakeKind = hsSetup[7:6];
         wire [2:0] reqWaitUse = hsSetup[5:3];
         wire [2:0] skewDelayCount = hsSetup[2:0];
         wire cmdWr = wrEn && wrIdx == CMD_IDX;
         wire [2:0] code = wrByte[7:5];
         wire dataWr = wrEn && wrIdx == DATA_IDX;
         wire dataRd = rdEn && rdIdx == DATA_IDX;
         wire matchEvt = matchHit[g] & ~matchLast & bitPort & (matchMode != `HSPCS_PMS_OFF)
            & ~faultFlag; // [R16]
         wire errEvt = matchEvt & serviceRequest & haltOnFault; // [R12]
         wire byteIn = hasIn & ~inputFull & strobeFall[g];
         reg byteOut;
         wire setUs = cmdWr && code == `HSPCS_CMD_SET_US; // [R21]
         wire clrUs = cmdWr && (code == `HSPCS_CMD_CLR_US || code == `HSPCS_CMD_CLR_BOTH);
         wire setReq = cmdWr && code == `HSPCS_CMD_SET_REQ; // [R21]
         wire clrReq = (cmdWr && (code == `HSPCS_CMD_CLR_REQ || code == `HSPCS_CMD_CLR_BOTH))
            | (~bitPort & ((dataRd & hasIn) | (dataWr & hasOut))); // [R11]
         wire reqSet = byteIn | byteOut | (matchEvt & ~serviceRequest) | errEvt | setReq;
         wire oreShow = bitPort ? (matchMode != `HSPCS_PMS_VECTOR) : outputEmpty; // [R13]
         wire irfShow = hasIn & inputFull; // [R14]
         wire pmfShow = (matchMode != `HSPCS_PMS_OFF) & matchFlag; // [R15]
         assign statusV[g*8+:8] = {underService, intEnable, serviceRequest, faultFlag,
            oreShow, irfShow, pmfShow, haltOnFault};
         assign hsV[g*8+:8] = hsSetup;
         assign modeV[g*8+:8] = modeReg;
         assign inV[g*8+:8] = inData;
         assign iusV[g] = underService;
         assign reqV[g] = intEnable & serviceRequest & ~underService; // [R10]
         hspcs_deskew skew (
            .clock(clock),
            .reset(reset),
            .start(skewStart),
            .enable(skewTimerOn & (portKind == `HSPCS_KIND_OUT)), // [R20] [R6]
            .count(skewDelayCount), // [R5]
            .done(skewDone)
         );
         always @* begin
            byteOut = 1'b0;
            if (txState == TX_VALID && !bitPort) begin
               case (handshakeKind) // [R1]
                  `HSPCS_HSK_PULSED: byteOut = 1'b1;
                  `HSPCS_HSK_STROBED: byteOut = ackRise[g];
                  default: byteOut = ackLevel[g];
               endcase
            end
         end
         always @(posedge clock) begin
            if (reset) begin
               hsSetup <= `HSPCS_HS_RESET; // [R7]
               modeReg <= `HSPCS_MODE_RESET;
               underService <= 1'b0; // [R8]
               intEnable <= 1'b0;
               serviceRequest <= 1'b0;
               faultFlag <= 1'b0;
               haltOnFault <= 1'b0;
               outputEmpty <= 1'b1; // [R8]
               inputFull <= 1'b0;
               matchFlag <= 1'b0;
               phase <= 1'b0;
               matchLast <= 1'b0;
               inData <= 8'h00;
               txState <= TX_IDLE;
               skewStart <= 1'b0;
               newByteValidN[g] <= 1'b1;
               dataOut[g*8+:8] <= 8'h00;
               reqWait[g] <= 1'b0;
            end else begin
               skewStart <= 1'b0;
               matchLast <= matchHit[g];
               phase <= ~phase;
               if (wrEn && wrIdx == HS_IDX) hsSetup <= wrByte; // [R7]
               if (wrEn && wrIdx == MODE_IDX) modeReg <= wrByte;
               if (cmdWr) haltOnFault <= wrByte[0]; // [R17]
               if (setUs || ackSel[g]) underService <= 1'b1; // [R9]
               else if (clrUs) underService <= 1'b0; // [R9]
               if (cmdWr && code == `HSPCS_CMD_SET_IE) intEnable <= 1'b1; // [R21]
               else if (cmdWr && code == `HSPCS_CMD_CLR_IE) intEnable <= 1'b0; // [R21]
               if (reqSet) serviceRequest <= 1'b1; // [R11]
               else if (clrReq) serviceRequest <= 1'b0; // [R11]
               if (!haltOnFault) faultFlag <= 1'b0; // [R12]
               else if (errEvt) faultFlag <= 1'b1; // [R12]
               else if (clrReq) faultFlag <= 1'b0; // [R12]
               if (bitPort) begin
                  inData <= pinData[g*8+:8];
                  if (phase) matchFlag <= matchHit[g]; // [R15]
                  if (dataWr) dataOut[g*8+:8] <= wrByte;
               end else if (byteIn) begin
                  inData <= pinData[g*8+:8];
                  matchFlag <= matchHit[g]; // [R15]
               end
               if (byteIn) inputFull <= 1'b1; // [R14]
               else if (dataRd) inputFull <= 1'b0; // [R14]
               case (txState)
                  TX_IDLE: begin
                     if (dataWr && hasOut) begin
                        dataOut[g*8+:8] <= wrByte;
                        outputEmpty <= 1'b0; // [R13]
                        skewStart <= 1'b1; // [R5]
                        txState <= TX_SKEW;
                     end
                  end
                  TX_SKEW: begin
                     if (skewDone) begin
                        newByteValidN[g] <= 1'b0; // [R5]
                        txState <= TX_VALID;
                     end
                  end
                  TX_VALID: begin
                     if (byteOut) begin
                        newByteValidN[g] <= 1'b1;
                        outputEmpty <= 1'b1; // [R13]
                        matchFlag <= matchHit[g]; // [R15]
                        txState <= TX_IDLE;
                     end
                  end
                  default: txState <= TX_IDLE;
               endcase
               if (bitPort) begin
                  reqWait[g] <= 1'b0; // [R7]
               end else begin
                  case (reqWaitUse) // [R3]
                     `HSPCS_RW_OUT_WAIT: reqWait[g] <= ~outputEmpty;
                     `HSPCS_RW_IN_WAIT: reqWait[g] <= ~inputFull;
                     `HSPCS_RW_SPECIAL: reqWait[g] <= (outputEmpty & hasOut) | (inputFull & hasIn);
                     `HSPCS_RW_OUT_REQ: reqWait[g] <= outputEmpty;
                     `HSPCS_RW_IN_REQ: reqWait[g] <= inputFull;
                     default: reqWait[g] <= 1'b0;
                  endcase
               end
            end
         end
      end
   endgenerate
endmodule

// file: tb/hspcs_partner.sv
// Purpose: External peer that answers output bytes and sends input bytes.
// Assumes: Port A is the output side and port B the input side.
// Notes: Released input lines show the inverse of the last byte.
`timescale 1ns/1ps
module hspcs_partner (
   input wire clock,
   input wire [1:0] newByteValidN,
   output logic [1:0] ackIn,
   output logic [1:0] strobeInN,
   output logic [15:0] dataIn
);
   // ****
   // Acknowledge follows valid low after a settle and drops once valid rises.
   // ****
   logic [5:0] lowA = 6'h00;
   logic [5:0] lowB = 6'h00;
   initial begin
      ackIn = 2'h0;
      strobeInN = 2'h3;
      dataIn = 16'h0000;
   end
   always @(posedge clock) begin
      lowA <= {lowA[4:0], ~newByteValidN[0]};
      lowB <= {lowB[4:0], ~newByteValidN[1]};
      ackIn <= {&lowB, &lowA};
   end
   task send(input logic [7:0] b);
      @(posedge clock);
      dataIn[15:8] <= b;
      repeat (3) @(posedge clock);
      strobeInN[1] <= 1'b0;
      repeat (6) @(posedge clock);
      strobeInN[1] <= 1'b1;
      repeat (3) @(posedge clock);
      dataIn[15:8] <= ~b;
   endtask
endmodule

// file: tb/hspcs_top_asserts.sv
// Purpose: Port-level checks of bus answers and handshake pins.
// Assumes: Sees only ports of the top module.
// Notes: Bound after the module.
`timescale 1ns/1ps
module hspcs_top_asserts (
   input wire clock,
   input wire reset,
   input wire awvalid,
   input wire awready,
   input wire wvalid,
   input wire wready,
   input wire [1:0] bresp,
   input wire bvalid,
   input wire bready,
   input wire arvalid,
   input wire arready,
   input wire [31:0] rdata,
   input wire rvalid,
   input wire rready,
   input wire chainIn,
   input wire irqOutN,
   input wire [1:0] newByteValidN,
   input wire [15:0] dataOut
);
   // ****
   // Properties.
   // ****
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);
   sequence s_wr_take;
      awvalid && awready && wvalid && wready;
   endsequence
   sequence s_rd_take;
      arvalid && arready;
   endsequence
   chk_write_answer: assert property (s_wr_take |-> ##[1:2] bvalid)
      else $error("write answer missing");
   chk_read_answer: assert property (s_rd_take |-> ##[1:3] rvalid)
      else $error("read answer missing");
   chk_b_stands: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write answer dropped");
   chk_r_stands: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
      else $error("read answer dropped");
   chk_bus_refused: assert property (bvalid |-> !awready && !wready)
      else $error("write taken during answer");
   chk_read_refused: assert property (rvalid |-> !arready && rdata[31:8] == 24'h000000)
      else $error("read taken during answer");
   chk_reset_flags: assert property ($fell(reset) |-> irqOutN && newByteValidN == 2'h3)
      else $error("pins wrong after reset");
   chk_data_stable: assert property (!newByteValidN[0] |-> $stable(dataOut[7:0]))
      else $error("data moved while valid");
   chk_irq_chain: assert property (!irqOutN |-> $past(chainIn, 3))
      else $error("request without chain enable");
endmodule
bind hspcs_top hspcs_top_asserts chk (.clock, .reset, .awvalid, .awready, .wvalid, .wready,
   .bresp, .bvalid, .bready, .arvalid, .arready, .rdata, .rvalid, .rready, .chainIn, .irqOutN,
   .newByteValidN, .dataOut);

// file: tb/tb_hspcs_top.sv
// Purpose: Register and handshake tests of the two-port block.
// Assumes: Port A drives bytes out, port B takes bytes in.
// Notes: Byte address is four times the register index.
`timescale 1ns/1ps
`include "hspcs_consts.vh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fails++; \
   $display("unexpected t=%0t got %h exp %h", $time, (g), (e)); end end
module tb_hspcs_top;
   logic clock = 1'b0;
   logic reset = 1'b1;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic [31:0] wdata = 32'h00000000;
   logic [3:0] wstrb = 4'hF;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic intAck = 1'b0, chainIn = 1'b1;
   logic [1:0] matchHit = 2'h0;
   wire awready, wready, bvalid, arready, rvalid, irqOutN, chainOut;
   wire [1:0] bresp, rresp, newByteValidN, reqWait, ackIn, strobeInN;
   wire [31:0] rdata;
   wire [15:0] dataIn, dataOut;
   int fails = 0, num_checks = 0, cyc = 0, gOff, n, i;
   logic [7:0] d;
   logic [1:0] rs;
   logic [7:0] cmdW [9] = '{8'hC0, 8'h80, 8'h40, 8'h60, 8'hE0, 8'hA0, 8'h80, 8'h20, 8'h1F};
   logic [7:0] expS [9] = '{8'h48, 8'h68, 8'hE8, 8'h68, 8'h28, 8'h08, 8'h28, 8'h08, 8'h09};
   logic [8:0] irqE = 9'b111110101;
   hspcs_top dut (.clock(clock), .reset(reset), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .dataIn(dataIn), .strobeInN(strobeInN), .ackIn(ackIn), .matchHit(matchHit),
      .intAck(intAck), .chainIn(chainIn), .dataOut(dataOut), .newByteValidN(newByteValidN),
      .reqWait(reqWait), .irqOutN(irqOutN), .chainOut(chainOut));
   hspcs_partner peer (.clock(clock), .newByteValidN(newByteValidN), .ackIn(ackIn),
      .strobeInN(strobeInN), .dataIn(dataIn));
   // ****
   // Clock, timeout and bus tasks.
   // ****
   initial forever #5 clock = ~clock;
   always @(posedge clock) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         report_and_stop();
      end
   end
   task report_and_stop;
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task wr(input logic [5:0] a, input logic [7:0] v);
      @(posedge clock);
      awaddr <= {a, 2'b00};
      wdata <= {24'h000000, v};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clock);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (awvalid && !awready || wvalid && !wready);
      while (bvalid !== 1'b1) @(posedge clock);
      bready <= 1'b0;
   endtask
   task rd(input logic [5:0] a);
      @(posedge clock);
      araddr <= {a, 2'b00};
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge clock); while (arready !== 1'b1);
      arvalid <= 1'b0;
      while (rvalid !== 1'b1) @(posedge clock);
      d = rdata[7:0];
      rs = rresp;
      rready <= 1'b0;
   endtask
   task xfer(input logic [7:0] v);
      wr(`HSPCS_IDX_DATA_A, v);
      n = 0;
      while (newByteValidN[0] !== 1'b0) begin
         @(posedge clock);
         n++;
      end
      `CHK(dataOut[7:0], v)
   endtask
   // ****
   // Main sequence.
   // ****
   initial begin
      repeat (2) @(posedge clock);
      reset <= 1'b0;
      rd(`HSPCS_IDX_CMD_A);
      `CHK(d, 8'h08)
      wr(`HSPCS_IDX_HS_A, 8'hA5);
      rd(`HSPCS_IDX_HS_A);
      `CHK(d, 8'hA5)
      `CHK(reqWait[0], 1'b0)
      rd(`HSPCS_IDX_HS_B);
      `CHK(d, `HSPCS_HS_RESET)
      wr(`HSPCS_IDX_PC_DIR, 8'h05);
      rd(`HSPCS_IDX_PC_DIR);
      `CHK(d, 8'hF5)
      rd(6'h3F);
      `CHK(rs, `HSPCS_RESP_SLVERR)
      for (i = 0; i < 9; i++) begin
         wr(`HSPCS_IDX_CMD_A, cmdW[i]);
         repeat (5) @(posedge clock);
         `CHK({irqOutN, chainOut}, {irqE[i], ~expS[i][7]})
         rd(`HSPCS_IDX_CMD_A);
         `CHK(d, expS[i])
      end
      wr(`HSPCS_IDX_CMD_A, 8'hC0);
      wr(`HSPCS_IDX_CMD_A, 8'h80);
      chainIn <= 1'b0;
      repeat (5) @(posedge clock);
      `CHK({irqOutN, chainOut}, 2'b10)
      chainIn <= 1'b1;
      intAck <= 1'b1;
      repeat (6) @(posedge clock);
      intAck <= 1'b0;
      repeat (4) @(posedge clock);
      rd(`HSPCS_IDX_CMD_A);
      `CHK(d, 8'hE8)
      wr(`HSPCS_IDX_CMD_A, 8'h20);
      wr(`HSPCS_IDX_CMD_A, 8'hE0);
      wr(`HSPCS_IDX_MODE_A, {`HSPCS_KIND_OUT, 6'h00});
      for (i = 0; i < 4; i++) begin
         wr(`HSPCS_IDX_HS_A, {i[1:0], 6'h00});
         xfer(8'h30 + i[7:0]);
         if (i == 0) gOff = n;
         if (i != 2) begin
            rd(`HSPCS_IDX_CMD_A);
            `CHK(d[3], 1'b0)
         end
         while (newByteValidN[0] !== 1'b1) @(posedge clock);
         repeat (4) @(posedge clock);
         rd(`HSPCS_IDX_CMD_A);
         `CHK(d[3:2], 2'b10)
      end
      wr(`HSPCS_IDX_HS_A, 8'h03);
      xfer(8'hC3);
      `CHK(n, gOff)
      repeat (20) @(posedge clock);
      wr(`HSPCS_IDX_MODE_A, {`HSPCS_KIND_OUT, 6'h01});
      xfer(8'h5A);
      `CHK(n - gOff, 8)
      repeat (20) @(posedge clock);
      wr(`HSPCS_IDX_HS_A, {2'h0, `HSPCS_RW_OUT_REQ, 3'h0});
      repeat (5) @(posedge clock);
      `CHK(reqWait[0], 1'b1)
      wr(`HSPCS_IDX_HS_A, 8'h00);
      repeat (5) @(posedge clock);
      `CHK(reqWait[0], 1'b0)
      wr(`HSPCS_IDX_MODE_B, 8'h02);
      wr(`HSPCS_IDX_CMD_B, 8'h01);
      repeat (2) begin
         matchHit <= 2'h2;
         repeat (3) @(posedge clock);
         matchHit <= 2'h0;
         repeat (3) @(posedge clock);
      end
      rd(`HSPCS_IDX_CMD_B);
      `CHK(d, 8'h39)
      wr(`HSPCS_IDX_CMD_B, 8'hA0);
      wr(`HSPCS_IDX_MODE_B, {`HSPCS_KIND_IN, 6'h00});
      peer.send(8'h96);
      repeat (5) @(posedge clock);
      rd(`HSPCS_IDX_CMD_B);
      `CHK(d[2], 1'b1)
      rd(`HSPCS_IDX_DATA_B);
      `CHK(d, 8'h96)
      rd(`HSPCS_IDX_CMD_B);
      `CHK(d[2], 1'b0)
      report_and_stop();
   end
endmodule
